// [kfet_cfg.svh]
`ifndef KFET_CFG_SVH
`define KFET_CFG_SVH
// Frequencies are in 10 Hz units
`define KFET_FREQ_MIN 22'h0003e8
`define KFET_FREQ_MAX 22'h2dc6bf
`define KFET_FREQ_RST 22'h16e360
`define KFET_STEP_SSB 22'h002710
`define KFET_STEP_SSB_FAST 22'h0186a0
`define KFET_STEP_AM 22'h0001f4
`define KFET_STEP_AM_FAST 22'h0003e8
// Knob rates per revolution
`define KFET_RATE_CW 22'h000078
`define KFET_RATE_SSB 22'h0001e0
`define KFET_RATE_AM 22'h000960
`define KFET_RATE_FAST 22'h0003c0
`define KFET_RATE_AM_FAST 22'h0012c0
`define KFET_RATE_SHIFT 22'h005dc0
// Band register defaults
`define KFET_NBANDS 9
`define KFET_BAND0 22'h02bf20
`define KFET_BAND1 22'h055730
`define KFET_BAND2 22'h0aae60
`define KFET_BAND3 22'h0f6950
`define KFET_BAND4 22'h155cc0
`define KFET_BAND5 22'h1b91d0
`define KFET_BAND6 22'h200b20
`define KFET_BAND7 22'h25faa8
`define KFET_BAND8 22'h2ab980
// Entry display
`define KFET_NDIG 7
`define KFET_DIG_BLANK 4'hf
`define KFET_DIG_NONE 4'he
`define KFET_DP_MASK 7'h24
`define KFET_UNITS_MIN 4'h3
// Filters: 0=6.0 1=2.4 2=1.8 3=0.5 4=0.25
`define KFET_FILT_SSB_MAX 3'h2
`define KFET_FILT_MAX 3'h4
// Register port
`define KFET_REG_FREQ 4'h0
`define KFET_REG_STATUS 4'h4
`define KFET_REG_CTRL 4'h8
`endif

// [kfet_panel.sv]
`timescale 1ns/10ps
`default_nettype none
module kfet_panel (
   // Clock
   input wire logic clk_i,
   // Keypad, knob and modem line
   output var kfet_pkg::kfet_key_t key_o,
   output var logic am_held_o,
   output var kfet_pkg::kfet_enc_t enc_o,
   output var logic fsk_pin_o
);
   logic mark_q = 1'b0;
   initial key_o = '0;
   initial enc_o = '0;
   initial am_held_o = 1'b0;
   // Released line floats high on the pull-up
   always_comb fsk_pin_o = !mark_q;
   task press(input kfet_pkg::kfet_kcode_t c, input logic [3:0] d, input logic [3:0] b);
      @(posedge clk_i);
      key_o <= '{1'b1, c, d, b};
      @(posedge clk_i);
      key_o <= {1'b0, ~key_o[11:0]};
      repeat (3) @(posedge clk_i);
      #5;
   endtask : press
   task press_am(input kfet_pkg::kfet_kcode_t c);
      @(posedge clk_i);
      am_held_o <= 1'b1;
      press(c, 4'h0, 4'h0);
      @(posedge clk_i);
      am_held_o <= 1'b0;
   endtask : press_am
   task knob(input logic up);
      @(posedge clk_i);
      enc_o <= '{1'b1, up};
      @(posedge clk_i);
      enc_o <= '{1'b0, !up};
      repeat (3) @(posedge clk_i);
      #5;
   endtask : knob
   task modem(input logic m);
      @(posedge clk_i);
      mark_q <= m;
      repeat (5) @(posedge clk_i);
      #5;
   endtask : modem
endmodule : kfet_panel
`default_nettype wire

// [kfet_pkg.sv]
package kfet_pkg;
   typedef enum logic [3:0] {
      KC_DIGIT, KC_ENTER, KC_UP, KC_DOWN, KC_FAST, KC_SHIFT, KC_SWAP,
      KC_LSB, KC_USB, KC_CW, KC_AM, KC_FM, KC_TUNE, KC_BAND
   } kfet_kcode_t;
   typedef struct packed {
      logic valid;
      kfet_kcode_t code;
      logic [3:0] digit;
      logic [3:0] band;
   } kfet_key_t;
   typedef struct packed {
      logic step;
      logic up;
   } kfet_enc_t;
   typedef enum logic [2:0] {M_LSB, M_USB, M_CW, M_AM, M_FM, M_FSK} kfet_mode_t;
   typedef enum logic {E_IDLE, E_ENTRY} kfet_estate_t;
endpackage : kfet_pkg

// [kfet_props.sv]
`timescale 1ns/10ps
`default_nettype none
`include "kfet_cfg.svh"
module kfet_props (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Operator side
   input wire kfet_pkg::kfet_key_t key_i,
   input wire kfet_pkg::kfet_enc_t enc_i,
   input wire logic fsk_pin_i,
   // Outputs
   input wire logic [21:0] freq_o,
   input wire logic vfo_sel_o,
   input wire kfet_pkg::kfet_mode_t mode_o,
   input wire logic lsb_demod_o,
   input wire logic [4:0] led_o,
   input wire logic fsk_mark_o,
   input wire logic entry_o,
   input wire logic [6:0][3:0] disp_o,
   input wire logic [6:0] dp_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A knob step in the same cycle overrides the up, down and band keys
   wire logic k_ok = key_i.valid && !entry_o && !enc_i.step;
   entry_blank_a: assert property (
      k_ok && key_i.code == kfet_pkg::KC_ENTER |=> entry_o && disp_o == {7{`KFET_DIG_BLANK}})
      else $error("entry did not open blank");
   sep_fixed_a: assert property (dp_o == `KFET_DP_MASK)
      else $error("separator mask moved");
   step_coarse_a: assert property (
      k_ok && key_i.code == kfet_pkg::KC_UP && mode_o inside {kfet_pkg::M_LSB, kfet_pkg::M_USB,
      kfet_pkg::M_CW, kfet_pkg::M_FSK} && freq_o < `KFET_FREQ_MAX - `KFET_STEP_SSB_FAST
      |=> (freq_o - $past(freq_o)) inside {`KFET_STEP_SSB, `KFET_STEP_SSB_FAST})
      else $error("sideband step wrong");
   mode_led_a: assert property (
      k_ok && key_i.code == kfet_pkg::KC_FM |=> mode_o == kfet_pkg::M_FM ##1 led_o == 5'h01)
      else $error("mode indicator wrong");
   vfo_swap_a: assert property (k_ok && key_i.code == kfet_pkg::KC_SWAP |=> vfo_sel_o != $past(vfo_sel_o))
      else $error("oscillator not swapped");
   fsk_dark_a: assert property ((mode_o == kfet_pkg::M_FSK) [*2] |-> led_o == 5'h00)
      else $error("indicator lit in shift keying");
   lsb_recv_a: assert property (
      1'b1 |=> lsb_demod_o == ($past(mode_o) == kfet_pkg::M_LSB || $past(mode_o) == kfet_pkg::M_FSK))
      else $error("lower sideband select wrong");
   mark_follow_a: assert property ((mode_o == kfet_pkg::M_FSK) [*4] |-> fsk_mark_o == !$past(fsk_pin_i, 3))
      else $error("mark does not follow pin");
   freq_range_a: assert property (freq_o >= `KFET_FREQ_MIN && freq_o <= `KFET_FREQ_MAX)
      else $error("frequency out of range");
   entry_c: cover property (entry_o ##1 !entry_o);
   fsk_c: cover property (mode_o == kfet_pkg::M_FSK && fsk_mark_o);
   swap_c: cover property (vfo_sel_o);
endmodule : kfet_props
bind kfet_top kfet_props kfet_props_i (.clk_i, .rst_i, .key_i, .enc_i, .fsk_pin_i, .freq_o, .vfo_sel_o,
   .mode_o, .lsb_demod_o, .led_o, .fsk_mark_o, .entry_o, .disp_o, .dp_o);
`default_nettype wire

// [kfet_top.sv]
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "kfet_cfg.svh"
// What this block does
// (R01) Entry key starts entry showing blanks
// (R02) Short entry closed, missing digits zero
// (R03) Seventh digit completes entry, 10 Hz
// (R04) First zero absorbed, second zero shown
// (R05) Multi-digit without zero means 3-29.999 MHz
// (R06) Decimal separators at fixed positions
// (R07) Sideband/CW/FSK steps 100 kHz or 1 MHz
// (R08) AM/FM steps 5 kHz or 10 kHz
// (R09) Normal knob rates 1.2/4.8/24 kHz
// (R10) Fast knob rates 9.6/48, shifted 240
// (R11) Band key moves band, again swaps registers
// (R12) Swap key changes active oscillator
// (R13) Mode key selects mode and indicator
// (R14) AM with sideband key gives AM transmit
// (R15) Shift then CW selects FSK, indicators off
// (R16) Modem drives low mark, open is space
// (R17) FSK receives lower sideband, all filters
// (R18) Tune keys transmitter until turned off
// (R19) Sideband allows only three widest filters; the code drops this limit during AM transmit
// (R20) Frequencies clamp to tuning range
module kfet_top #(
   parameter int ENC_PPR = 40
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Operator controls
   input wire kfet_pkg::kfet_key_t key_i,
   input wire logic am_held_i,
   input wire kfet_pkg::kfet_enc_t enc_i,
   input wire logic fsk_pin_i,
   // Register port
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [31:0] rdata_o,
   // Synthesizer and mode controls
   output logic [21:0] freq_o,
   output logic vfo_sel_o,
   output kfet_pkg::kfet_mode_t mode_o,
   output logic am_tx_o,
   output logic lsb_demod_o,
   output logic [4:0] led_o,
   output logic [2:0] filter_o,
   output logic filter_bad_o,
   output logic key_down_o,
   output logic fsk_mark_o,
   // Entry display
   output logic entry_o,
   output logic [6:0][3:0] disp_o,
   output logic [6:0] dp_o
);
   // A count that does not divide the slowest rate would make knob steps uneven
   if (ENC_PPR < 1 || (`KFET_RATE_CW % ENC_PPR) != 0) begin : g_ppr_check
      $error("ENC_PPR must divide the slowest knob rate");
   end

   kfet_pkg::kfet_estate_t st_q;
   logic [6:0][3:0] slots_q, slots_n;
   logic [2:0] cnt_q, cnt_n;
   logic zabs_q, zabs_n, commit_c, stay_c;
   logic shift_q, fast_q, sfast_q, tune_q, active_q;
   logic [21:0] vfo_q [2];
   logic [21:0] band_a_q [`KFET_NBANDS];
   logic [21:0] band_b_q [`KFET_NBANDS];
   logic [3:0] band_q;
   logic band_ok_q;
   kfet_pkg::kfet_mode_t mode_q;
   logic am_tx_q;
   logic [2:0] ctrl_q;
   logic fsk_s1_q, fsk_s2_q;
   logic kv;
   logic [21:0] step_c, rate_c, entry_val_c;
   logic ssb_c;

   assign kv = key_i.valid;
   assign ssb_c = (mode_q == kfet_pkg::M_LSB) || (mode_q == kfet_pkg::M_USB);

   function automatic logic [21:0] entry_value(input logic [6:0][3:0] s, input logic units);
      logic [6:0][3:0] t;
      logic [23:0] acc;
      t = units ? {`KFET_DIG_BLANK, s[6:1]} : s;
      acc = 24'h000000;
      for (int i = 6; i >= 0; i--) begin
         acc = 24'(acc * 24'h00000a) + ((t[i] > 4'h9) ? 24'h000000 : {20'h00000, t[i]}); // R02
      end
      return acc[21:0];
   endfunction : entry_value

   function automatic logic [21:0] clamp(input logic signed [24:0] v);
      if (v < $signed({3'h0, `KFET_FREQ_MIN})) begin
         return `KFET_FREQ_MIN; // R20
      end else if (v > $signed({3'h0, `KFET_FREQ_MAX})) begin
         return `KFET_FREQ_MAX; // R20
      end
      return v[21:0];
   endfunction : clamp

   function automatic logic [21:0] band_dflt(input logic [3:0] b);
      case (b)
         4'h0: return `KFET_BAND0;
         4'h1: return `KFET_BAND1;
         4'h2: return `KFET_BAND2;
         4'h3: return `KFET_BAND3;
         4'h4: return `KFET_BAND4;
         4'h5: return `KFET_BAND5;
         4'h6: return `KFET_BAND6;
         4'h7: return `KFET_BAND7;
         default: return `KFET_BAND8;
      endcase
   endfunction : band_dflt

   // Digit entry sequencing
   always_comb begin
      slots_n = slots_q;
      cnt_n = cnt_q;
      zabs_n = zabs_q;
      commit_c = 1'b0;
      stay_c = 1'b0;
      if (kv && st_q == kfet_pkg::E_IDLE && key_i.code == kfet_pkg::KC_ENTER) begin
         slots_n = {7{`KFET_DIG_BLANK}}; // R01
         cnt_n = 3'h0;
         zabs_n = 1'b0;
         stay_c = 1'b1;
      end else if (kv && st_q == kfet_pkg::E_ENTRY) begin
         if (key_i.code == kfet_pkg::KC_DIGIT && key_i.digit <= 4'h9) begin
            if (cnt_q == 3'h0 && key_i.digit == 4'h0) begin
               zabs_n = 1'b1; // R04
            end
            slots_n[3'h6 - cnt_q] = key_i.digit;
            cnt_n = cnt_q + 3'h1;
            commit_c = (cnt_q == 3'h6); // R03
            stay_c = !commit_c;
         end else if (key_i.code == kfet_pkg::KC_ENTER) begin
            commit_c = (cnt_q != 3'h0); // R02
         end
      end
   end

   // Leading 1 or 2 of a longer entry is the tens digit
   assign entry_val_c = entry_value(slots_n, !zabs_n && (cnt_n == 3'h1 || slots_n[6] >= `KFET_UNITS_MIN)); // R05

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= kfet_pkg::E_IDLE;
         slots_q <= {7{`KFET_DIG_BLANK}};
         cnt_q <= 3'h0;
         zabs_q <= 1'b0;
      end else begin
         st_q <= stay_c ? kfet_pkg::E_ENTRY : (kv ? kfet_pkg::E_IDLE : st_q);
         slots_q <= slots_n;
         cnt_q <= cnt_n;
         zabs_q <= zabs_n;
      end
   end

   // Display: absorbed zero removes its position
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disp_o <= {7{`KFET_DIG_BLANK}};
         entry_o <= 1'b0;
      end else begin
         disp_o <= slots_n;
         if (zabs_n) begin
            disp_o[6] <= `KFET_DIG_NONE; // R04
         end
         entry_o <= stay_c || (st_q == kfet_pkg::E_ENTRY && !kv);
      end
   end
   assign dp_o = `KFET_DP_MASK; // R06

   // Step sizes and knob rates
   always_comb begin
      if (mode_q == kfet_pkg::M_AM || mode_q == kfet_pkg::M_FM) begin
         step_c = fast_q ? `KFET_STEP_AM_FAST : `KFET_STEP_AM; // R08
         rate_c = fast_q ? `KFET_RATE_AM_FAST : `KFET_RATE_AM; // R09 R10
      end else begin
         step_c = fast_q ? `KFET_STEP_SSB_FAST : `KFET_STEP_SSB; // R07
         rate_c = fast_q ? `KFET_RATE_FAST : (ssb_c ? `KFET_RATE_SSB : `KFET_RATE_CW); // R09 R10
      end
      if (sfast_q) begin
         rate_c = `KFET_RATE_SHIFT; // R10
      end
      rate_c = rate_c / 22'(ENC_PPR);
   end

   // Shift, fast and tune toggles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shift_q <= 1'b0;
         fast_q <= 1'b0;
         sfast_q <= 1'b0;
         tune_q <= 1'b0;
      end else if (kv && st_q == kfet_pkg::E_IDLE) begin
         shift_q <= (key_i.code == kfet_pkg::KC_SHIFT) && !shift_q;
         if (key_i.code == kfet_pkg::KC_FAST) begin
            if (shift_q) begin
               sfast_q <= !sfast_q;
            end else begin
               fast_q <= !fast_q;
            end
         end
         if (key_i.code == kfet_pkg::KC_TUNE) begin
            tune_q <= !tune_q; // R18
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         active_q <= 1'b0;
      end else if (kv && st_q == kfet_pkg::E_IDLE && key_i.code == kfet_pkg::KC_SWAP) begin
         active_q <= !active_q; // R12
      end
   end

   // Active oscillator frequency and band registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vfo_q[0] <= `KFET_FREQ_RST;
         vfo_q[1] <= `KFET_FREQ_RST;
         for (int i = 0; i < `KFET_NBANDS; i++) begin
            band_a_q[i] <= band_dflt(4'(i));
            band_b_q[i] <= band_dflt(4'(i));
         end
         band_q <= 4'h0;
         band_ok_q <= 1'b0;
      end else if (commit_c) begin
         vfo_q[active_q] <= clamp({3'h0, entry_val_c}); // R20
      end else if (enc_i.step && st_q == kfet_pkg::E_IDLE) begin
         vfo_q[active_q] <= clamp(enc_i.up ? $signed({3'h0, vfo_q[active_q]}) + $signed({3'h0, rate_c})
                                           : $signed({3'h0, vfo_q[active_q]}) - $signed({3'h0, rate_c}));
      end else if (kv && st_q == kfet_pkg::E_IDLE) begin
         case (key_i.code)
            kfet_pkg::KC_UP: vfo_q[active_q] <= clamp($signed({3'h0, vfo_q[active_q]}) + $signed({3'h0, step_c}));
            kfet_pkg::KC_DOWN: vfo_q[active_q] <= clamp($signed({3'h0, vfo_q[active_q]}) - $signed({3'h0, step_c}));
            kfet_pkg::KC_BAND: begin
               if (key_i.band < 4'(`KFET_NBANDS)) begin
                  if (band_ok_q && key_i.band == band_q) begin
                     vfo_q[active_q] <= band_b_q[band_q]; // R11
                     band_b_q[band_q] <= vfo_q[active_q];
                  end else begin
                     if (band_ok_q) begin
                        band_a_q[band_q] <= vfo_q[active_q];
                     end
                     vfo_q[active_q] <= band_a_q[key_i.band]; // R11
                     band_q <= key_i.band;
                     band_ok_q <= 1'b1;
                  end
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Mode selection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q <= kfet_pkg::M_USB;
         am_tx_q <= 1'b0;
      end else if (kv && st_q == kfet_pkg::E_IDLE) begin
         case (key_i.code)
            kfet_pkg::KC_LSB: begin
               mode_q <= kfet_pkg::M_LSB; // R13
               am_tx_q <= am_held_i; // R14
            end
            kfet_pkg::KC_USB: begin
               mode_q <= kfet_pkg::M_USB; // R13
               am_tx_q <= am_held_i; // R14
            end
            kfet_pkg::KC_CW: begin
               mode_q <= shift_q ? kfet_pkg::M_FSK : kfet_pkg::M_CW; // R15
               am_tx_q <= 1'b0;
            end
            kfet_pkg::KC_AM: begin
               mode_q <= kfet_pkg::M_AM; // R13
               am_tx_q <= 1'b0;
            end
            kfet_pkg::KC_FM: begin
               mode_q <= kfet_pkg::M_FM; // R13
               am_tx_q <= 1'b0;
            end
            kfet_pkg::KC_TUNE: begin
               if (!tune_q) begin
                  mode_q <= kfet_pkg::M_CW; // R18
                  am_tx_q <= 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Indicators: usb, lsb, cw, am, fm; all dark in FSK
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         led_o <= 5'h00;
         lsb_demod_o <= 1'b0;
      end else begin
         led_o <= {mode_q == kfet_pkg::M_USB, mode_q == kfet_pkg::M_LSB, mode_q == kfet_pkg::M_CW,
                   mode_q == kfet_pkg::M_AM || (am_tx_q && ssb_c), mode_q == kfet_pkg::M_FM}; // R13 R14 R15
         lsb_demod_o <= (mode_q == kfet_pkg::M_LSB) || (mode_q == kfet_pkg::M_FSK); // R17
      end
   end

   // Filter choice; sideband receive without AM transmit cannot use the narrow filters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         filter_o <= 3'h0;
         filter_bad_o <= 1'b0;
      end else begin
         filter_bad_o <= ssb_c && !am_tx_q && ctrl_q > `KFET_FILT_SSB_MAX; // R19
         if (ssb_c && !am_tx_q && ctrl_q > `KFET_FILT_SSB_MAX) begin
            filter_o <= `KFET_FILT_SSB_MAX; // R19
         end else begin
            filter_o <= ctrl_q; // R17
         end
      end
   end

   // Keying line is asynchronous; open pin reads space via pull-up
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fsk_s1_q <= 1'b1;
         fsk_s2_q <= 1'b1;
         fsk_mark_o <= 1'b0;
         key_down_o <= 1'b0;
      end else begin
         fsk_s1_q <= fsk_pin_i;
         fsk_s2_q <= fsk_s1_q;
         fsk_mark_o <= (mode_q == kfet_pkg::M_FSK) && !fsk_s2_q; // R16
         key_down_o <= tune_q; // R18
      end
   end

   // Register port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= 3'h0;
         rdata_o <= 32'h00000000;
      end else begin
         if (we_i && addr_i == `KFET_REG_CTRL) begin
            ctrl_q <= (wdata_i[2:0] > `KFET_FILT_MAX) ? `KFET_FILT_MAX : wdata_i[2:0];
         end
         rdata_o <= 32'h00000000;
         if (re_i) begin
            case (addr_i)
               `KFET_REG_FREQ: rdata_o <= {10'h000, vfo_q[active_q]};
               `KFET_REG_STATUS: rdata_o <= {22'h000000, filter_bad_o, st_q == kfet_pkg::E_ENTRY, tune_q,
                                             sfast_q, fast_q, active_q, am_tx_q, mode_q};
               `KFET_REG_CTRL: rdata_o <= {29'h00000000, ctrl_q};
               default: rdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   assign freq_o = vfo_q[active_q];
   assign vfo_sel_o = active_q;
   assign mode_o = mode_q;
   assign am_tx_o = am_tx_q;
endmodule : kfet_top
`default_nettype wire

// [test_keypad_freq_entry_tuning.sv]
`timescale 1ns/10ps
`default_nettype none
`include "kfet_cfg.svh"
module test_keypad_freq_entry_tuning;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic we = 1'b0;
   logic re = 1'b0;
   logic [31:0] rdata, rd;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   kfet_pkg::kfet_key_t key;
   kfet_pkg::kfet_enc_t enc;
   kfet_pkg::kfet_mode_t mode;
   logic am_held, fsk_pin, vfo, am_tx, lsb, fbad, kdown, mark, entry;
   logic [21:0] freq;
   logic [4:0] led;
   logic [2:0] filt;
   logic [6:0][3:0] disp;
   logic [6:0] dp;
   string es[5] = '{"118", "1423456", "18", "0084", "5"};
   logic [21:0] ef[5] = '{22'h120160, 22'h15b860, 22'h1b7740, 22'h014820, 22'h07a120};
   kfet_panel kfet_panel_i (.clk_i(clk_i), .key_o(key), .am_held_o(am_held), .enc_o(enc), .fsk_pin_o(fsk_pin));
   kfet_top kfet_top_i (.clk_i(clk_i), .rst_i(rst_i), .key_i(key), .am_held_i(am_held), .enc_i(enc),
      .fsk_pin_i(fsk_pin), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
      .freq_o(freq), .vfo_sel_o(vfo), .mode_o(mode), .am_tx_o(am_tx), .lsb_demod_o(lsb), .led_o(led),
      .filter_o(filt), .filter_bad_o(fbad), .key_down_o(kdown), .fsk_mark_o(mark), .entry_o(entry),
      .disp_o(disp), .dp_o(dp));
   initial begin
      forever #25 clk_i = ~clk_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task key1(input kfet_pkg::kfet_kcode_t c);
      kfet_panel_i.press(c, 4'h0, 4'h0);
   endtask : key1
   task dig(input string s);
      for (int i = 0; i < s.len(); i++) begin
         kfet_panel_i.press(kfet_pkg::KC_DIGIT, 4'(s[i] - 8'h30), 4'h0);
      end
   endtask : dig
   task regwr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk_i);
      we <= 1'b0;
   endtask : regwr
   task regrd(input logic [3:0] a);
      @(posedge clk_i);
      addr <= a;
      re <= 1'b1;
      @(posedge clk_i);
      re <= 1'b0;
      #5;
      rd = rdata;
   endtask : regrd
   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run
   // Whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         complete_run();
      end
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #5;
      chk(freq, `KFET_FREQ_RST, "reset frequency");
      chk(mode, kfet_pkg::M_USB, "reset mode");
      chk(dp, `KFET_DP_MASK, "separators");
      $display("test reset done");
      key1(kfet_pkg::KC_ENTER);
      chk(entry, 1'b1, "entry open");
      chk(disp, {7{`KFET_DIG_BLANK}}, "blank row");
      dig("0");
      chk(disp[6], `KFET_DIG_NONE, "zero absorbed");
      dig("18");
      key1(kfet_pkg::KC_ENTER);
      chk(freq, 22'h02bf20, "leading zero entry");
      for (int i = 0; i < 5; i++) begin
         key1(kfet_pkg::KC_ENTER);
         dig(es[i]);
         if (i != 1)
            key1(kfet_pkg::KC_ENTER);
         chk(freq, ef[i], "entry value");
         chk(entry, 1'b0, "entry closed");
      end
      $display("test entry done");
      key1(kfet_pkg::KC_UP);
      chk(freq, 22'h07c830, "step fine");
      key1(kfet_pkg::KC_FAST);
      key1(kfet_pkg::KC_UP);
      chk(freq, 22'h094ed0, "step coarse");
      key1(kfet_pkg::KC_FM);
      chk(led, 5'h01, "fm indicator");
      key1(kfet_pkg::KC_UP);
      chk(freq, 22'h0952b8, "fm coarse step");
      kfet_panel_i.knob(1'b1);
      chk(freq, 22'h095330, "knob coarse");
      key1(kfet_pkg::KC_FAST);
      kfet_panel_i.knob(1'b1);
      chk(freq, 22'h09536c, "knob fine");
      $display("test steps done");
      key1(kfet_pkg::KC_SHIFT);
      key1(kfet_pkg::KC_CW);
      chk(mode, kfet_pkg::M_FSK, "shift keying mode");
      chk(led, 5'h00, "indicators off");
      chk(lsb, 1'b1, "lower sideband receive");
      kfet_panel_i.modem(1'b1);
      chk(mark, 1'b1, "mark");
      kfet_panel_i.modem(1'b0);
      chk(mark, 1'b0, "space");
      key1(kfet_pkg::KC_ENTER);
      dig("001");
      key1(kfet_pkg::KC_ENTER);
      key1(kfet_pkg::KC_DOWN);
      chk(freq, `KFET_FREQ_MIN, "clamp low");
      $display("test shift keying done");
      kfet_panel_i.press_am(kfet_pkg::KC_LSB);
      chk(am_tx, 1'b1, "am transmit");
      chk(led, 5'h0a, "am and lsb lit");
      key1(kfet_pkg::KC_AM);
      chk(am_tx, 1'b0, "am receive only");
      chk(led, 5'h02, "am lit");
      kfet_panel_i.press(kfet_pkg::KC_BAND, 4'h0, 4'h2);
      chk(freq, `KFET_BAND2, "band load");
      key1(kfet_pkg::KC_UP);
      kfet_panel_i.press(kfet_pkg::KC_BAND, 4'h0, 4'h2);
      kfet_panel_i.press(kfet_pkg::KC_BAND, 4'h0, 4'h2);
      chk(freq, 22'h0ab054, "band exchange");
      key1(kfet_pkg::KC_SWAP);
      chk(vfo, 1'b1, "swap to b");
      chk(freq, `KFET_FREQ_RST, "b frequency");
      key1(kfet_pkg::KC_SWAP);
      chk(freq, 22'h0ab054, "back to a");
      key1(kfet_pkg::KC_TUNE);
      chk(kdown, 1'b1, "tune keyed");
      chk(mode, kfet_pkg::M_CW, "tune in cw");
      key1(kfet_pkg::KC_TUNE);
      chk(kdown, 1'b0, "tune released");
      $display("test keys done");
      key1(kfet_pkg::KC_LSB);
      regwr(`KFET_REG_CTRL, 32'h3);
      repeat (3) @(posedge clk_i);
      #5;
      chk(fbad, 1'b1, "narrow filter flagged");
      chk(filt, `KFET_FILT_SSB_MAX, "narrow filter held back");
      regrd(`KFET_REG_CTRL);
      chk(rd, 32'h3, "ctrl readback");
      regwr(`KFET_REG_CTRL, 32'h6);
      regrd(`KFET_REG_CTRL);
      chk(rd, 32'h4, "ctrl saturate");
      regrd(4'hc);
      chk(rd, 32'h0, "unmapped read");
      regrd(`KFET_REG_FREQ);
      chk(rd, 32'h000ab054, "freq read");
      regwr(`KFET_REG_CTRL, 32'h2);
      repeat (3) @(posedge clk_i);
      #5;
      chk(fbad, 1'b0, "wide filter allowed");
      $display("test registers done");
      complete_run();
   end
endmodule : test_keypad_freq_entry_tuning
`default_nettype wire
